/* src/call_mode_select.sv */
// Call mode select register block with AHB-Lite slave and instruction timing issue port.
`timescale 1ns/1ps
`include "call_mode_map.svh"
module call_mode_select (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic op_valid,
  input wire call_mode_pkg::call_op_t op_code,
  output logic op_done,
  output logic op_illegal,
  output logic [1:0] op_push_bytes,
  output logic legacy_mode,
  output logic stack_bank,
  output logic subclock_feedback_disable
);
  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [3:0] sbms;
    logic feedback;
    logic [31:0] rdata;
    call_mode_pkg::exec_state_t st;
    logic [2:0] count;
    logic mode_lat;
    logic done;
    logic illegal;
    logic [1:0] push;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] dec_push;
  logic [2:0] dec_cycles;
  logic dec_illegal;

  // The mode is sampled at issue, so a register write never changes a call already running.
  call_timing timing_u (
    .legacy_mode(s_q.sbms[`MODE_BIT]),
    .op(op_code),
    .push_bytes(dec_push),
    .cycles(dec_cycles),
    .illegal(dec_illegal)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.wr_pend = 1'b0;
    s_d.rd_pend = 1'b0;
    if (s_q.wr_pend)
    begin
      if (s_q.addr == `SBMS_OFFSET)
      begin
        s_d.sbms = hwdata[3:0];
      end
      else if (s_q.addr == `SUBCLK_OFFSET)
      begin
        s_d.feedback = hwdata[`FEEDBACK_BIT];
      end
    end
    if (hsel && hready && htrans[1])
    begin
      s_d.addr = haddr;
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
      s_d.rdata = 32'h0;
      if (!hwrite)
      begin
        case (haddr)
          `SBMS_OFFSET: s_d.rdata = {28'h0, s_q.sbms};
          `SUBCLK_OFFSET: s_d.rdata = {31'h0, s_q.feedback};
          `STATUS_OFFSET: s_d.rdata = {27'h0, s_q.push, s_q.mode_lat,
            s_q.st == call_mode_pkg::st_busy, s_q.illegal};
          default: s_d.rdata = 32'h0;
        endcase
      end
    end
    case (s_q.st)
      call_mode_pkg::st_idle:
      begin
        if (op_valid && op_code != call_mode_pkg::op_none)
        begin
          s_d.mode_lat = s_q.sbms[`MODE_BIT];
          s_d.illegal = dec_illegal;
          s_d.push = dec_illegal ? 2'h0 : dec_push;
          s_d.count = dec_cycles - 3'h1;
          if (dec_cycles == 3'h1 || dec_illegal)
          begin
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.st = call_mode_pkg::st_busy;
          end
        end
      end
      call_mode_pkg::st_busy:
      begin
        s_d.count = s_q.count - 3'h1;
        if (s_q.count == 3'h1)
        begin
          s_d.done = 1'b1;
          s_d.st = call_mode_pkg::st_idle;
        end
      end
      default:
      begin
        s_d.st = call_mode_pkg::st_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.sbms <= `SBMS_RESET;
      s_q.feedback <= `SUBCLK_RESET;
      s_q.mode_lat <= 1'b1;
      s_q.st <= call_mode_pkg::st_idle;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign op_done = s_q.done;
  assign op_illegal = s_q.illegal;
  assign op_push_bytes = s_q.push;
  assign legacy_mode = s_q.sbms[`MODE_BIT];
  assign stack_bank = s_q.sbms[`BANK_BIT];
  assign subclock_feedback_disable = s_q.feedback;
endmodule

/* inc/call_mode_map.svh */
// Register map, field positions, reset values and cycle counts of the call mode block.
// ----------------------------------------------------------------------------
// How it works
// - Bit 3 of the stack bank register set to 1 selects legacy call mode and 0 selects extended call mode.
// - Reset forces the mode bit to 1, so the processor starts in legacy call mode.
// - A subroutine call pushes 2 stack bytes in legacy mode and 3 in extended mode.
// - An absolute call takes 3 machine cycles in legacy mode and 4 in extended mode; a fixed-area call 2 and 3.
// - Extended jump and call exist only in extended mode, so software clears the mode bit before using them.
// - The stack bank register is written with a 4-bit memory write.
// - In both modes the stack sits in memory bank 0 or 1, as the register's lowest bit chooses.
// ----------------------------------------------------------------------------
`ifndef CALL_MODE_MAP_SVH
`define CALL_MODE_MAP_SVH
`define SBMS_OFFSET 8'h00
`define SUBCLK_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define MODE_BIT 3
`define BANK_BIT 0
`define FEEDBACK_BIT 0
`define SBMS_RESET 4'h8
`define SUBCLK_RESET 1'b0
`define LEGACY_STACK_BYTES 2'h2
`define EXTENDED_STACK_BYTES 2'h3
`define LEGACY_ABS_CYCLES 3'h3
`define EXTENDED_ABS_CYCLES 3'h4
`define LEGACY_FIX_CYCLES 3'h2
`define EXTENDED_FIX_CYCLES 3'h3
`define EXT_JUMP_CYCLES 3'h3
`endif

/* inc/call_mode_pkg.sv */
// Types shared by the call mode block.
package call_mode_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_abs_call,
    op_fix_call,
    op_ext_call,
    op_ext_jump
  } call_op_t;
  typedef enum {
    st_idle,
    st_busy
  } exec_state_t;
endpackage

/* src/call_timing.sv */
// Per-instruction stack depth, cycle count and legality decode for the current call mode.
`timescale 1ns/1ps
`include "call_mode_map.svh"
module call_timing (
  input wire logic legacy_mode,
  input wire call_mode_pkg::call_op_t op,
  output logic [1:0] push_bytes,
  output logic [2:0] cycles,
  output logic illegal
);
  always_comb
  begin
    push_bytes = 2'h0;
    cycles = 3'h1;
    illegal = 1'b0;
    case (op)
      call_mode_pkg::op_abs_call:
      begin
        push_bytes = legacy_mode ? `LEGACY_STACK_BYTES : `EXTENDED_STACK_BYTES;
        cycles = legacy_mode ? `LEGACY_ABS_CYCLES : `EXTENDED_ABS_CYCLES;
      end
      call_mode_pkg::op_fix_call:
      begin
        push_bytes = legacy_mode ? `LEGACY_STACK_BYTES : `EXTENDED_STACK_BYTES;
        cycles = legacy_mode ? `LEGACY_FIX_CYCLES : `EXTENDED_FIX_CYCLES;
      end
      call_mode_pkg::op_ext_call:
      begin
        push_bytes = `EXTENDED_STACK_BYTES;
        cycles = `EXTENDED_ABS_CYCLES;
        illegal = legacy_mode;
      end
      call_mode_pkg::op_ext_jump:
      begin
        cycles = `EXT_JUMP_CYCLES;
        illegal = legacy_mode;
      end
      default:
      begin
        push_bytes = 2'h0;
      end
    endcase
  end
endmodule

/* test/call_mode_select_chk.sv */
// Assertion checker for the call mode select block.
`timescale 1ns/1ps
module call_mode_select_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic op_valid,
  input wire call_mode_pkg::call_op_t op_code,
  input wire logic op_done,
  input wire logic op_illegal,
  input wire logic [1:0] op_push_bytes,
  input wire logic legacy_mode,
  input wire logic stack_bank
);
  // A busy shadow lets an issue be seen without reading the status register.
  logic busy_q;
  logic tk, ab, fx;
  assign tk = op_valid && op_code != call_mode_pkg::op_none && (!busy_q || op_done);
  assign ab = tk && op_code == call_mode_pkg::op_abs_call;
  assign fx = tk && op_code == call_mode_pkg::op_fix_call;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      busy_q <= 1'b0;
    else
      busy_q <= tk || (busy_q && !op_done);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_wr;
    hsel && hready && htrans[1] && hwrite && haddr == 8'h00 ##1 1'b1;
  endsequence
  a_mode_bit: assert property (s_wr |=> legacy_mode == $past(hwdata[3]))
    else $error("mode bit wrong");
  a_bank_bit: assert property (s_wr |=> stack_bank == $past(hwdata[0]))
    else $error("bank bit wrong");
  a_reset_mode: assert property ($fell(sys_rst) |-> legacy_mode)
    else $error("no legacy mode after reset");
  a_push_bytes: assert property (ab || fx |=>
    op_push_bytes == ($past(legacy_mode) ? 2'h2 : 2'h3)) else $error("push count wrong");
  a_abs_legacy: assert property (ab && legacy_mode |=> !op_done [*2] ##1 op_done)
    else $error("legacy absolute call length wrong");
  a_abs_ext: assert property (ab && !legacy_mode |=> !op_done [*3] ##1 op_done)
    else $error("extended absolute call length wrong");
  a_fix_legacy: assert property (fx && legacy_mode |=> !op_done ##1 op_done)
    else $error("legacy fixed call length wrong");
  a_ext_refused: assert property (tk && op_code == call_mode_pkg::op_ext_call &&
    legacy_mode |=> op_done && op_illegal) else $error("extended call not refused");
  a_fix_ext: assert property (fx && !legacy_mode |=> !op_done [*2] ##1 op_done)
    else $error("extended fixed call length wrong");
  a_jump_refused: assert property (tk && op_code == call_mode_pkg::op_ext_jump &&
    legacy_mode |=> op_done && op_illegal) else $error("extended jump not refused");
endmodule
bind call_mode_select call_mode_select_chk u_chk (.clk, .sys_rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .op_valid, .op_code, .op_done, .op_illegal, .op_push_bytes,
  .legacy_mode, .stack_bank);

/* test/test_call_mode_select.sv */
// Self-checking bench of the call mode select block.
`timescale 1ns/1ps
`include "call_mode_map.svh"
module test_call_mode_select;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, op_valid, op_done, op_illegal;
  logic legacy_mode, stack_bank, subclock_feedback_disable;
  logic [7:0] haddr;
  logic [1:0] htrans, op_push_bytes;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  call_mode_pkg::call_op_t op_code;
  int miscompares, num_checks, cyc, n;
  // Legacy entries first, then extended; order is abs, fix, ext call, ext jump.
  logic [2:0] cy [0:7] = '{3'h3, 3'h2, 3'h1, 3'h1, 3'h4, 3'h3, 3'h4, 3'h3};
  logic [1:0] pb [0:7] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0};
  assign hready = hreadyout;
  call_mode_select dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp(), .op_valid, .op_code, .op_done, .op_illegal,
    .op_push_bytes, .legacy_mode, .stack_bank, .subclock_feedback_disable);
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    // Let the data phase edge settle so callers see the updated register outputs.
    #1;
  endtask
  task op(input int k, input int m);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= call_mode_pkg::call_op_t'(k);
    @(posedge clk);
    op_valid <= 1'b0;
    // The issue cycle counts as the first machine cycle.
    n = 1;
    #1;
    while (op_done !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, cy[m*4+k-1]);
    chk(op_push_bytes, pb[m*4+k-1]);
    chk(op_illegal, m == 0 && k > 2);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      miscompares++;
      stop_test;
    end
  end
  initial
  begin
    {sys_rst, hsel, hwrite, op_valid, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    op_code = call_mode_pkg::op_none;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(legacy_mode, 1'b1);
    bus(0, `SBMS_OFFSET, 0, r);
    chk(r, 32'h8);
    bus(0, 8'h0C, 0, r);
    chk(r, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      bus(1, `SBMS_OFFSET, m ? 32'h0 : 32'h9, r);
      for (int k = 1; k < 5; k++)
        op(k, m);
      chk({legacy_mode, stack_bank}, m ? 2'h0 : 2'h3);
      bus(0, `SBMS_OFFSET, 0, r);
      chk(r, m ? 32'h0 : 32'h9);
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({legacy_mode, stack_bank}, 2'h2);
    bus(1, `SBMS_OFFSET, 32'h8, r);
    op(3, 0);
    bus(0, `STATUS_OFFSET, 0, r);
    chk(r, 32'h5);
    bus(1, `SUBCLK_OFFSET, 32'h1, r);
    chk(subclock_feedback_disable, 1'b1);
    stop_test;
  end
endmodule
